// file: design/adc_serial_out_defines.svh
// Timing and layout constants of the serial result sequencer.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef ADC_SERIAL_OUT_DEFINES_SVH
`define ADC_SERIAL_OUT_DEFINES_SVH
`define REF_CLK_HZ        200000000
`define POR_TIME_US       1000
`define POR_CYCLES        ((`POR_TIME_US * (`REF_CLK_HZ / 1000000)))
`define SW_FREQ_HZ        76800
`define SW_HALF_CYCLES    ((`REF_CLK_HZ / `SW_FREQ_HZ) / 2)
`define CONV_SW_CYCLES    16'd256
`define WORD_BITS         32
`define EDGE_CNT_W        6
`define EOC_BUSY          1'b1
`define EOC_DONE          1'b0
`endif

// file: design/adc_serial_out_pkg.sv
// Types of the serial result sequencer.
// Used by the sequencer only; the link-side shifter does not import it.
package adc_serial_out_pkg;
    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11,
        ST_OUT  = 2'b10
    } seq_state_t;
endpackage

// file: design/adc_link_shifter.sv
// Link-side shifter: makes the serial clock and shifts the word out.
// Runs on link_clk; start arrives as a toggle from the system domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_out_defines.svh"
module adc_link_shifter (
    input  wire logic        link_clk,
    input  wire logic        nrst_link,
    input  wire logic        start_tgl,
    input  wire logic [31:0] word,
    output logic             done_tgl,
    output logic             sck_ff,
    output logic             sdo_ff
);
    logic [2:0]              sync_ff;
    logic [31:0]             sh_ff;
    logic [`EDGE_CNT_W-1:0]  cnt_ff;
    logic                    busy_ff;
    logic                    dtgl_ff;
    logic                    go;

    assign go       = sync_ff[2] ^ sync_ff[1];
    assign done_tgl = dtgl_ff;

    always_ff @(posedge link_clk) begin
        if (!nrst_link) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], start_tgl};
        end
    end

    // Serial clock, one link period per phase
    always_ff @(posedge link_clk) begin
        if (!nrst_link) begin
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
            sck_ff  <= 1'b1;
            sdo_ff  <= 1'b1;
            sh_ff   <= 32'h0;
            dtgl_ff <= 1'b0;
        end else if (go && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= '0;
            sck_ff  <= 1'b0;
            sdo_ff  <= `EOC_DONE;
            // Top bit is the status slot, already shown as the done level
            sh_ff   <= {word[30:0], 1'b0};
        end else if (busy_ff) begin
            // Data held one link cycle past edge 32 for the receiver
            if (cnt_ff == `EDGE_CNT_W'(`WORD_BITS)) begin
                busy_ff <= 1'b0;
                sdo_ff  <= `EOC_BUSY;
                dtgl_ff <= ~dtgl_ff;
            end else if (!sck_ff) begin
                sck_ff <= 1'b1;
                cnt_ff <= cnt_ff + `EDGE_CNT_W'd1;
            end else begin
                sck_ff <= 1'b0;
                sdo_ff <= sh_ff[31];
                sh_ff  <= {sh_ff[30:0], 1'b0};
            end
        end else begin
            sck_ff <= 1'b1;
            sdo_ff <= `EOC_BUSY;
        end
    end
endmodule // adc_link_shifter
`default_nettype wire

// file: design/adc_continuous_serial_output.sv
// Continuous-conversion result sequencer with internal serial clock.
// Assumes a conversion core supplies a 32-bit result word on demand.
//
// Functional notes
// - Mode choice is latched when the power-on delay of 1 ms expires.
// - Weak pull-up on the clock pin during reset; high picks internal mode.
// - During conversion data is driven high; clock is driven high in internal mode only.
// - The device makes the clock; 32 rising edges form the output cycle.
// - Data changes on each falling clock edge of the output cycle.
// - After edge 32 data goes high and clock stays high while converting.
// - Sampling clock is 76800 Hz internal or half the external rate.
// - Clock and data stay static during conversion.
// - Notch select low/high picks 60/50 Hz; a toggling input is the clock.
// - The finished result is captured at done; the shifter loads it on the start toggle.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_out_defines.svh"
module adc_continuous_serial_output
    import adc_serial_out_pkg::*;
#(
    parameter int POR_CYCLES = `POR_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        link_clk,
    input  wire logic        nrst_link,
    input  wire logic        sck_in,
    input  wire logic        notch_freq_select,
    input  wire logic        ext_osc_freq,
    input  wire logic [31:0] conv_result,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             sck_pullup_en,
    output logic             sdo_out,
    output logic             sdo_oe,
    output logic             int_sck_mode,
    output logic             ext_osc_active,
    output logic             notch_50hz,
    output logic             sw_clk,
    output logic             conv_busy
);
    seq_state_t  state_ff;
    seq_state_t  nxt_state;
    logic [31:0] por_cnt_ff;
    logic [1:0]  sck_sync_ff;
    logic [1:0]  f_sync_ff;
    logic [2:0]  osc_sync_ff;
    logic [2:0]  done_sync_ff;
    logic        mode_ff;
    logic        start_tgl_ff;
    logic [31:0] word_ff;
    logic [15:0] sw_cnt_ff;
    logic [15:0] conv_cnt_ff;
    logic        sw_ff;
    logic        ext_ff;
    logic [7:0]  act_cnt_ff;
    logic        osc_edge;
    logic        link_done;
    logic        sw_tick;
    logic        lk_sck;
    logic        lk_sdo;
    logic        lk_done_tgl;

    // ************************************************
    // Input synchronisers
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sck_sync_ff  <= 2'h3;
            f_sync_ff    <= 2'h0;
            osc_sync_ff  <= 3'h0;
            done_sync_ff <= 3'h0;
        end else begin
            sck_sync_ff  <= {sck_sync_ff[0], sck_in};
            f_sync_ff    <= {f_sync_ff[0], notch_freq_select};
            osc_sync_ff  <= {osc_sync_ff[1:0], ext_osc_freq};
            done_sync_ff <= {done_sync_ff[1:0], lk_done_tgl};
        end
    end
    assign osc_edge  = osc_sync_ff[2] ^ osc_sync_ff[1];
    assign link_done = done_sync_ff[2] ^ done_sync_ff[1];

    // ************************************************
    // Power-on delay and mode latch
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            por_cnt_ff <= 32'h0;
            mode_ff    <= 1'b0;
        end else if (state_ff == ST_POR) begin
            por_cnt_ff <= por_cnt_ff + 32'h1;
            if (por_cnt_ff == 32'(POR_CYCLES - 1)) begin
                mode_ff <= sck_sync_ff[1];
            end
        end
    end
    assign sck_pullup_en = (state_ff == ST_POR);
    assign int_sck_mode  = mode_ff;

    // ************************************************
    // Notch select and external oscillator detect
    // ************************************************
    // Input counts as external clock while edges keep arriving
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            act_cnt_ff <= 8'h0;
            ext_ff     <= 1'b0;
        end else if (osc_edge) begin
            act_cnt_ff <= 8'hff;
            ext_ff     <= 1'b1;
        end else if (act_cnt_ff != 8'h0) begin
            act_cnt_ff <= act_cnt_ff - 8'h1;
        end else begin
            ext_ff <= 1'b0;
        end
    end
    assign ext_osc_active = ext_ff;
    assign notch_50hz     = f_sync_ff[1] & ~ext_ff;

    // ************************************************
    // Sampling switch clock
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sw_cnt_ff <= 16'h0;
            sw_ff     <= 1'b0;
        end else if (ext_ff) begin
            sw_cnt_ff <= 16'h0;
            if (osc_edge && osc_sync_ff[1]) begin
                sw_ff <= ~sw_ff;
            end
        end else if (sw_cnt_ff == 16'(`SW_HALF_CYCLES - 1)) begin
            sw_cnt_ff <= 16'h0;
            sw_ff     <= ~sw_ff;
        end else begin
            sw_cnt_ff <= sw_cnt_ff + 16'h1;
        end
    end
    assign sw_clk  = sw_ff;
    assign sw_tick = (sw_cnt_ff == 16'h0) & ~sw_ff & ~ext_ff
                   | (ext_ff & osc_edge & osc_sync_ff[1] & sw_ff);

    // ************************************************
    // Conversion sequencer
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POR: begin
                if (por_cnt_ff == 32'(POR_CYCLES - 1)) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_cnt_ff == `CONV_SW_CYCLES && mode_ff) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: nxt_state = ST_OUT;
            ST_OUT: begin
                if (link_done) begin
                    nxt_state = ST_CONV;
                end
            end
            default: nxt_state = ST_POR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff <= ST_POR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            conv_cnt_ff <= 16'h0;
        end else if (state_ff != ST_CONV) begin
            conv_cnt_ff <= 16'h0;
        end else if (sw_tick && conv_cnt_ff != `CONV_SW_CYCLES) begin
            conv_cnt_ff <= conv_cnt_ff + 16'h1;
        end
    end

    // Result captured at done, handed over by toggle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            word_ff      <= 32'h0;
            start_tgl_ff <= 1'b0;
        end else if (state_ff == ST_DONE) begin
            word_ff      <= conv_result;
            start_tgl_ff <= ~start_tgl_ff;
        end
    end
    assign conv_busy = (state_ff == ST_CONV);

    // ************************************************
    // Link side
    // ************************************************
    adc_link_shifter u_shift (
        .link_clk  (link_clk),
        .nrst_link (nrst_link),
        .start_tgl (start_tgl_ff),
        .word      (word_ff),
        .done_tgl  (lk_done_tgl),
        .sck_ff    (lk_sck),
        .sdo_ff    (lk_sdo)
    );

    // Clock pin driven only in internal mode, data pin after power-on in both modes
    assign sck_out = lk_sck;
    assign sdo_out = lk_sdo;
    assign sck_oe  = mode_ff & (state_ff != ST_POR);
    assign sdo_oe  = (state_ff != ST_POR);
endmodule // adc_continuous_serial_output
`default_nettype wire

// file: verif/seq_port_chk.sv
// Port checker of the serial result sequencer.
// Bound to the top module; watches both clock domains.
`timescale 1ns/1ps
`default_nettype none
module seq_port_chk #(
    parameter int POR_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic nrst_link,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sck_pullup_en,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic int_sck_mode
);
    logic [15:0] por_cnt;
    logic [5:0]  rises;
    logic        sck_q;

    always_ff @(posedge ref_clk) begin
        if (!nrst)
            por_cnt <= 16'h0;
        else if (sck_pullup_en)
            por_cnt <= por_cnt + 16'h1;
    end

    // Rising clock edges of the current output cycle
    always_ff @(posedge link_clk) begin
        if (!nrst_link) begin
            sck_q <= 1'h1;
            rises <= 6'h0;
        end else begin
            sck_q <= sck_out;
            if (sck_out && sdo_out && sck_q)
                rises <= 6'h0;
            else if (sck_out && !sck_q)
                rises <= rises + 6'h1;
        end
    end

    pullup_rst_a: assert property (@(posedge ref_clk)
        !nrst |=> sck_pullup_en && !sck_oe && !sdo_oe)
        else $error("pull-up or enables wrong in reset");
    por_len_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(sck_pullup_en) |->
            por_cnt >= POR_CYCLES - 1 && por_cnt <= POR_CYCLES + 4)
        else $error("power-on phase length wrong");
    oe_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !sck_pullup_en && !$past(sck_pullup_en) |->
            sck_oe == int_sck_mode && sdo_oe && $stable(int_sck_mode))
        else $error("mode or enables wrong after power-on");
    frame_start_a: assert property (@(posedge link_clk)
        disable iff (!nrst_link) $fell(sck_out) && rises == 6'h0 |-> !sdo_out)
        else $error("data not low at conversion done");
    clk_toggle_a: assert property (@(posedge link_clk)
        disable iff (!nrst_link)
        rises != 6'h0 && (rises < 6'h1f || !sck_out) |=>
            sck_out != $past(sck_out))
        else $error("serial clock stalled inside output cycle");
    data_fall_a: assert property (@(posedge link_clk)
        disable iff (!nrst_link) $changed(sdo_out) && rises < 6'h20 |-> !sck_out)
        else $error("data changed while clock high");
    frame_end_a: assert property (@(posedge link_clk)
        disable iff (!nrst_link) rises == 6'h20 |-> sck_out && sdo_out)
        else $error("pins not high after last edge");
    conv_static_a: assert property (@(posedge link_clk)
        disable iff (!nrst_link)
        $rose(sdo_out) && sck_out |=> (sck_out && sdo_out) [*8])
        else $error("pins moved during conversion");
endmodule // seq_port_chk

bind adc_continuous_serial_output seq_port_chk #(
    .POR_CYCLES(POR_CYCLES)
) chk (.ref_clk, .nrst, .link_clk, .nrst_link, .sck_out, .sck_oe,
       .sck_pullup_en, .sdo_out, .sdo_oe, .int_sck_mode);
`default_nettype wire

// file: verif/rx_capture.sv
// Receiver model: takes the result word on rising serial clock edges.
// Samples the pins on the link clock.
`timescale 1ns/1ps
`default_nettype none
module rx_capture (
    input  wire logic        link_clk,
    input  wire logic        nrst_link,
    input  wire logic        sck,
    input  wire logic        sdo,
    output logic      [31:0] word,
    output logic             busy,
    output logic      [7:0]  frames
);
    logic       sck_q;
    logic [5:0] cnt;

    always_ff @(posedge link_clk) begin
        if (!nrst_link) begin
            sck_q  <= 1'h1;
            busy   <= 1'h0;
            frames <= 8'h0;
            cnt    <= 6'h0;
        end else begin
            sck_q <= sck;
            if (sck && !sck_q) begin
                word <= {word[30:0], sdo};
                busy <= (cnt != 6'h1f);
                cnt  <= (cnt == 6'h1f) ? 6'h0 : cnt + 6'h1;
                if (cnt == 6'h1f)
                    frames <= frames + 8'h1;
            end
        end
    end
endmodule // rx_capture
`default_nettype wire

// file: verif/testbench.sv
// Testbench of the continuous serial result sequencer.
// Needs the design, the receiver model and the port checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'h0, link_clk = 1'h0, nrst = 1'h0;
    logic        nrst_link = 1'h0, hold_low = 1'h0, ext_en = 1'h0;
    logic        notch_freq_select = 1'h0, ext_osc_freq = 1'h0;
    logic [31:0] conv_result = 32'h0, rx_word;
    logic [7:0]  frames;
    logic        rx_busy, sck_out, sck_oe, sck_pullup_en, sdo_out, sdo_oe;
    logic        int_sck_mode, ext_osc_active, notch_50hz, sw_clk, conv_busy;
    wire logic   sck_pin;
    int          n_errors = 0, checks_done = 0;

    // Board pull-up unless the host holds the pin low
    assign sck_pin = sck_oe ? sck_out : !hold_low;

    adc_continuous_serial_output #(.POR_CYCLES(20)) DUT (
        .ref_clk, .nrst, .link_clk, .nrst_link, .sck_in(sck_pin),
        .notch_freq_select, .ext_osc_freq, .conv_result, .sck_out, .sck_oe,
        .sck_pullup_en, .sdo_out, .sdo_oe, .int_sck_mode, .ext_osc_active,
        .notch_50hz, .sw_clk, .conv_busy);
    rx_capture rx (.link_clk, .nrst_link, .sck(sck_pin),
        .sdo(sdo_oe ? sdo_out : 1'h1), .word(rx_word), .busy(rx_busy),
        .frames);

    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        #32;
        forever #62.5 link_clk = ~link_clk;
    end
    initial forever begin
        repeat (4) @(posedge ref_clk);
        #1;
        if (ext_en)
            ext_osc_freq = ~ext_osc_freq;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task wait_ref(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task t_por(input logic low);
        int n;
        hold_low = low;
        nrst = 0;
        nrst_link = 0;
        wait_ref(8);
        check({sck_pullup_en, sck_oe, sdo_oe}, 3'h4);
        nrst = 1;
        n = 0;
        while (sck_pullup_en === 1'h1 && n < 100) begin
            wait_ref(1);
            n++;
        end
        check(n >= 19 && n <= 25, 1'h1);
        wait_ref(2);
        check({int_sck_mode, sck_oe}, {2{!low}});
        hold_low = 0;
        repeat (3) @(posedge link_clk);
        #1 nrst_link = 1;
    endtask

    task t_notch;
        for (int i = 0; i < 2; i++) begin
            notch_freq_select = i[0];
            wait_ref(6);
            check({ext_osc_active, notch_50hz}, {1'h0, i[0]});
        end
    endtask

    task t_swclk;
        int   n;
        logic q;
        ext_en = 1;
        wait_ref(300);
        n = 0;
        q = sw_clk;
        repeat (512) begin
            wait_ref(1);
            if (sw_clk && !q)
                n++;
            q = sw_clk;
        end
        check({ext_osc_active, n >= 31 && n <= 33}, 2'h3);
        check({ext_osc_active, notch_50hz}, 2'h2);
    endtask

    task t_frame(input logic [31:0] a, input logic [31:0] b);
        int         n;
        logic [7:0] f;
        conv_result = a;
        f = frames;
        n = 0;
        while (rx_busy !== 1'h1 && n < 20000) begin
            wait_ref(1);
            n++;
        end
        check(conv_busy, 1'h0);
        conv_result = b;
        while (frames === f && n < 40000) begin
            wait_ref(1);
            n++;
        end
        check(rx_word, a);
        wait_ref(60);
        check({sck_out, sdo_out}, 2'h3);
        check(conv_busy, 1'h1);
    endtask

    initial begin
        t_por(1'h1);
        t_por(1'h0);
        t_notch;
        t_swclk;
        t_frame(32'h5a3c_e1f7, 32'hffff_ffff);
        t_frame(32'h7fff_fffe, 32'h0000_0000);
        t_frame(32'h0000_0001, 32'h2468_ace0);
        wrap_up;
    end

    initial begin
        #400000;
        n_errors++;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
